/* File: rtl/tfw_pkg.sv */
// constants, types and register map of the tape function select and write path
// assumes a single 250 MHz clock and an APB register port
package tfw_pkg;

	localparam int CLK_MHZ         = 250;
	localparam int ACCEPT_DELAY_NS = 2000;
	localparam int ACCEPT_CYC      = (ACCEPT_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int FRAME_NS        = 8000;
	localparam int FRAME_CYC       = FRAME_NS * CLK_MHZ / 1000;
	localparam int BLANK_FRAMES    = 3;

	localparam logic [8:0]  ACCEPT_LAST = 9'(ACCEPT_CYC - 1);
	localparam logic [10:0] FRAME_LAST  = 11'(FRAME_CYC - 1);
	localparam logic [1:0]  BLANK_LAST  = 2'(BLANK_FRAMES - 1);

	// function word digit groups (third octal digit)
	localparam logic [2:0] GRP_FORMAT = 3'h0;
	localparam logic [2:0] GRP_MOTION = 3'h1;
	localparam logic [2:0] GRP_INT    = 3'h2;
	localparam logic [2:0] GRP_REVERSE = 3'h4;
	localparam logic [2:0] MAX_FORMAT = 3'h6;
	localparam logic [2:0] MAX_MOTION = 3'h6;
	localparam logic [2:0] MAX_INT    = 3'h5;
	localparam logic [2:0] MAX_REVERSE = 3'h1;

	// format group low digits
	localparam logic [2:0] FMT_RELEASE = 3'h0;
	localparam logic [2:0] FMT_BINARY  = 3'h1;
	localparam logic [2:0] FMT_CODED   = 3'h2;
	localparam logic [2:0] FMT_D556    = 3'h3;
	localparam logic [2:0] FMT_D200    = 3'h4;
	localparam logic [2:0] FMT_CLEAR   = 3'h5;
	localparam logic [2:0] FMT_D800    = 3'h6;

	typedef enum logic [1:0] {
		TFW_DEN_200 = 2'h0,
		TFW_DEN_556 = 2'h1,
		TFW_DEN_800 = 2'h2
	} tfw_density_t;

	localparam logic [5:0] ZERO_CHAR_SUB = 6'h0C;

	typedef enum logic [1:0] {
		F_IDLE = 2'h0,
		F_WAIT = 2'h1,
		F_ANS  = 2'h3
	} tfw_fstate_t;

	typedef enum logic [1:0] {
		W_IDLE  = 2'h0,
		W_EMIT  = 2'h1,
		W_BLANK = 2'h3,
		W_CHECK = 2'h2
	} tfw_wstate_t;

	typedef struct packed {
		logic [11:0] func_word;
		logic        func_strobe;
		logic [11:0] data_word;
		logic        data_parity;
		logic        data_strobe;
		logic        write_req;
		logic        handler_ready;
		logic        negate_conv;
		logic [6:0]  tape_frame;
		logic        tape_strobe;
	} tfw_pins_t;

	typedef struct packed {
		logic         binary_mode;
		tfw_density_t density;
		logic         reverse_read;
		logic [6:0]   motion;
		logic [2:0]   int_enable;
	} tfw_sel_t;

	localparam tfw_sel_t SEL_RESET = '{density: TFW_DEN_200, default: '0};

	// register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;

	localparam int ERR_XMIT  = 0;
	localparam int ERR_FRAME = 1;
	localparam int ERR_CHECK = 2;

	typedef struct packed {
		logic       record_open;
		tfw_sel_t   sel;
		logic [2:0] errors;
	} tfw_status_t;

	typedef struct packed {
		logic suppress_ad;
	} tfw_ctrl_t;

	localparam tfw_ctrl_t CTRL_RESET = '{default: '0};

endpackage

/* File: rtl/tfw_top.sv */
// function word decode and write data path of a magnetic tape controller
// assumes pins asynchronous to clock; registers on an APB slave port
//
// Summary of operation
// RQ1: after connect, the 12-bit function word with its strobe is captured and decoded.
// RQ2: an undefined function word is answered with refuse, never accept.
// RQ3: a defined function word is accepted only after its processing delay.
// RQ4: the channel holds word and strobe until accept or refuse arrives.
// RQ5: format codes select release, binary, coded, three densities, clear, reverse read.
// RQ6: third digit 1 selects the seven tape motion directives.
// RQ7: third digit 2 sets (even) or releases (odd) three interrupt requests.
// RQ8: each accepted selection is held in its own flip-flop.
// RQ9: transmission parity over 12 data bits is recomputed and compared on take.
// RQ10: word accept flag sets on data strobe only when handler and controller ready.
// RQ11: each word splits into two 6-bit characters sequenced by the disassembly counter.
// RQ12: suppress assembly mode writes only the low character, bits 6..11 dropped.
// RQ13: coded write inverts bit 5 when bit 4 is one, bit 4 unchanged.
// RQ14: bit 5 conversion is off in binary mode or under negate conversion.
// RQ15: coded write without negate replaces an all-zero character by 12.
// RQ16: seventh channel is one for odd ones in coded, even ones in binary.
// RQ17: write register toggles each channel for every one, holds for zero.
// RQ18: record end leaves three blank frames then writes the check character.
// RQ19: check character clears the write register, a one for each toggled channel.
// RQ20: read-back frames are vertical parity checked, mismatch sets frame parity error.
// RQ21: read toggle register must be zero after record and check, else check error.
// RQ22: every frame read from tape is vertical parity checked likewise.
// RQ23: word parity makes the count of ones in 13 bits odd.
// RQ24: upper six bits of each word are written first, then lower six.
// RQ25: accept follows a taken word; channel drops strobe before the next word.
// RQ26: disassembly counter returns to the upper character at each record start.
// RQ27: write and read toggle registers clear before a record's first frame.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module tfw_top
	import tfw_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire tfw_pins_t   pins_in,
	output var tfw_sel_t     sel_out,
	output logic             func_accept,
	output logic             func_refuse,
	output logic             word_accept,
	output logic      [6:0]  tape_write_level,
	output logic             tape_frame_strobe
);

	logic        rst_s1;
	logic        rst_n;
	tfw_pins_t   pin_s1;
	tfw_pins_t   pin_s;
	logic        tstb_d;

	// reset release and pin synchronisers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s  <= '0;
			tstb_d <= 1'b0;
		end else begin
			pin_s1 <= pins_in;
			pin_s  <= pin_s1;
			tstb_d <= pin_s.tape_strobe;
		end
	end

	logic tape_tick;
	assign tape_tick = pin_s.tape_strobe & ~tstb_d;

	// frame timing divider
	logic [10:0] fdiv;
	logic [10:0] next_fdiv;
	logic        frame_tick;

	always_comb begin
		next_fdiv = (fdiv == FRAME_LAST) ? '0 : fdiv + 11'h001;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) fdiv <= '0;
		else        fdiv <= next_fdiv;
	end

	assign frame_tick = (fdiv == FRAME_LAST);

	// APB slave
	tfw_ctrl_t   ctrl;
	tfw_ctrl_t   next_ctrl;
	tfw_status_t status;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        acc_done;
	logic        map_hit;
	logic [2:0]  err_clr;
	logic [2:0]  err_flags;
	logic        record_open;

	assign acc_done = psel & penable & pready;
	assign map_hit  = (paddr == REG_CTRL) | (paddr == REG_STATUS);
	assign status   = '{record_open: record_open, sel: sel_out, errors: err_flags};

	always_comb begin
		next_ctrl    = ctrl;
		next_pready  = psel & penable & ~pready;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		err_clr      = '0;
		if (psel && penable && !pready) begin
			next_pslverr = ~map_hit;
			next_prdata  = '0;
			if (!pwrite && paddr == REG_CTRL)   next_prdata = 32'(ctrl);
			if (!pwrite && paddr == REG_STATUS) next_prdata = 32'(status);
		end
		if (acc_done && pwrite && paddr == REG_CTRL)   next_ctrl = tfw_ctrl_t'(pwdata[0]);
		if (acc_done && pwrite && paddr == REG_STATUS) err_clr = pwdata[2:0];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl    <= CTRL_RESET;
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl    <= next_ctrl;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// function word decode
	tfw_fstate_t f_state;
	tfw_fstate_t next_f_state;
	logic [8:0]  fcnt;
	logic [8:0]  next_fcnt;
	logic [11:0] fcode;
	logic [11:0] next_fcode;
	tfw_sel_t    next_sel;
	logic        next_func_accept;
	logic        next_func_refuse;
	logic        code_legal;
	logic [2:0]  dg_c;
	logic [2:0]  dg_d;

	assign dg_c = pin_s.func_word[5:3];
	assign dg_d = pin_s.func_word[2:0];

	always_comb begin
		code_legal = 1'b0;
		if (pin_s.func_word[11:6] == '0) begin
			unique case (dg_c)
				GRP_FORMAT:  code_legal = (dg_d <= MAX_FORMAT);
				GRP_MOTION:  code_legal = (dg_d <= MAX_MOTION);
				GRP_INT:     code_legal = (dg_d <= MAX_INT);
				GRP_REVERSE: code_legal = (dg_d <= MAX_REVERSE);
				default:     code_legal = 1'b0;
			endcase
		end
	end

	always_comb begin
		next_f_state     = f_state;
		next_fcnt        = fcnt;
		next_fcode       = fcode;
		next_sel         = sel_out;
		next_func_accept = func_accept;
		next_func_refuse = func_refuse;
		unique case (f_state)
			F_IDLE: begin
				if (pin_s.func_strobe) begin
					next_fcode = pin_s.func_word; // see RQ1
					next_fcnt  = '0;
					if (code_legal) begin
						next_f_state = F_WAIT;
					end else begin
						next_func_refuse = 1'b1; // see RQ2
						next_f_state     = F_ANS;
					end
				end
			end
			F_WAIT: begin
				next_fcnt = fcnt + 9'h001;
				if (fcnt == ACCEPT_LAST) begin
					next_func_accept = 1'b1; // see RQ3
					next_f_state     = F_ANS;
					unique case (fcode[5:3]) // see RQ8
						GRP_FORMAT: begin
							unique case (fcode[2:0]) // see RQ5
								FMT_RELEASE: next_sel.motion = '0;
								FMT_BINARY:  next_sel.binary_mode = 1'b1;
								FMT_CODED:   next_sel.binary_mode = 1'b0;
								FMT_D556:    next_sel.density = TFW_DEN_556;
								FMT_D200:    next_sel.density = TFW_DEN_200;
								FMT_CLEAR:   next_sel = SEL_RESET;
								default:     next_sel.density = TFW_DEN_800;
							endcase
						end
						GRP_MOTION:  next_sel.motion = 7'h01 << fcode[2:0]; // see RQ6
						GRP_INT:     next_sel.int_enable[fcode[2:1]] = ~fcode[0]; // see RQ7
						default:     next_sel.reverse_read = fcode[0]; // see RQ5
					endcase
				end
			end
			F_ANS: begin
				if (!pin_s.func_strobe) begin
					next_func_accept = 1'b0;
					next_func_refuse = 1'b0;
					next_f_state     = F_IDLE;
				end
			end
			default: next_f_state = F_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			f_state     <= F_IDLE;
			fcnt        <= '0;
			fcode       <= '0;
			sel_out     <= SEL_RESET;
			func_accept <= 1'b0;
			func_refuse <= 1'b0;
		end else begin
			f_state     <= next_f_state;
			fcnt        <= next_fcnt;
			fcode       <= next_fcode;
			sel_out     <= next_sel;
			func_accept <= next_func_accept;
			func_refuse <= next_func_refuse;
		end
	end

	// write data path
	tfw_wstate_t w_state;
	tfw_wstate_t next_w_state;
	logic [11:0] word;
	logic [11:0] next_word;
	logic        disassembly_counter;
	logic        next_disassembly_counter;
	logic        word_accept_flag;
	logic        next_word_accept_flag;
	logic        next_word_accept;
	logic        next_record_open;
	logic [1:0]  blank_cnt;
	logic [1:0]  next_blank_cnt;
	logic [6:0]  write_toggle_stage;
	logic [6:0]  next_write_toggle_stage;
	logic [6:0]  write_output_stage;
	logic        next_frame_strobe;
	logic        xmit_err;
	logic        next_xmit_err;
	logic        word_take;
	logic        record_start;
	logic        check_sent;
	logic        coded_conv;
	logic [5:0]  ch;
	logic [6:0]  frame;

	assign word_take = (w_state == W_IDLE) & pin_s.write_req & pin_s.data_strobe
		& pin_s.handler_ready & ~word_accept & ~word_accept_flag; // see RQ10
	assign record_start = word_take & ~record_open;
	assign check_sent   = (w_state == W_CHECK) & frame_tick;
	assign coded_conv   = ~sel_out.binary_mode & ~pin_s.negate_conv; // see RQ14

	always_comb begin
		// upper character first unless suppressed
		ch = disassembly_counter ? word[5:0] : word[11:6]; // see RQ11 see RQ24 see RQ12
		if (coded_conv && ch[4]) ch[5] = ~ch[5]; // see RQ13
		if (coded_conv && ch == '0) ch = ZERO_CHAR_SUB; // see RQ15
		frame = {sel_out.binary_mode ? ~^ch : ^ch, ch}; // see RQ16
	end

	always_comb begin
		next_w_state             = w_state;
		next_word                = word;
		next_disassembly_counter = disassembly_counter;
		next_word_accept_flag    = word_accept_flag;
		next_word_accept         = word_accept & pin_s.data_strobe; // see RQ25
		next_record_open         = record_open;
		next_blank_cnt           = blank_cnt;
		next_write_toggle_stage  = write_toggle_stage;
		next_frame_strobe        = 1'b0;
		next_xmit_err            = xmit_err & ~err_clr[ERR_XMIT];
		unique case (w_state)
			W_IDLE: begin
				if (word_take) begin
					next_word_accept_flag    = 1'b1;
					next_word_accept         = 1'b1; // see RQ25
					next_word                = pin_s.data_word;
					next_disassembly_counter = ctrl.suppress_ad; // see RQ12 see RQ26
					next_record_open         = 1'b1;
					next_w_state             = W_EMIT;
					if (~^{pin_s.data_word, pin_s.data_parity}) next_xmit_err = 1'b1; // see RQ9 see RQ23
					if (record_start) next_write_toggle_stage = '0; // see RQ27
				end else if (record_open && !pin_s.write_req) begin
					next_blank_cnt = '0;
					next_w_state   = W_BLANK;
				end
			end
			W_EMIT: begin
				if (frame_tick) begin
					next_write_toggle_stage  = write_toggle_stage ^ frame; // see RQ17
					next_frame_strobe        = 1'b1;
					next_disassembly_counter = ~disassembly_counter;
					if (disassembly_counter) begin
						next_word_accept_flag = 1'b0;
						next_w_state          = W_IDLE;
					end
				end
			end
			W_BLANK: begin
				if (frame_tick) begin
					next_blank_cnt = blank_cnt + 2'h1;
					if (blank_cnt == BLANK_LAST) next_w_state = W_CHECK; // see RQ18
				end
			end
			W_CHECK: begin
				if (frame_tick) begin
					// ones exactly where a channel must flip back to zero
					next_write_toggle_stage = '0; // see RQ19
					next_frame_strobe       = 1'b1;
					next_record_open        = 1'b0;
					next_w_state            = W_IDLE;
				end
			end
			default: next_w_state = W_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			w_state             <= W_IDLE;
			word                <= '0;
			disassembly_counter <= 1'b0;
			word_accept_flag    <= 1'b0;
			word_accept         <= 1'b0;
			record_open         <= 1'b0;
			blank_cnt           <= '0;
			write_toggle_stage  <= '0;
			write_output_stage  <= '0;
			tape_write_level    <= '0;
			tape_frame_strobe   <= 1'b0;
			xmit_err            <= 1'b0;
		end else begin
			w_state             <= next_w_state;
			word                <= next_word;
			disassembly_counter <= next_disassembly_counter;
			word_accept_flag    <= next_word_accept_flag;
			word_accept         <= next_word_accept;
			record_open         <= next_record_open;
			blank_cnt           <= next_blank_cnt;
			write_toggle_stage  <= next_write_toggle_stage;
			write_output_stage  <= write_toggle_stage; // see RQ17
			tape_write_level    <= write_output_stage;
			tape_frame_strobe   <= next_frame_strobe;
			xmit_err            <= next_xmit_err;
		end
	end

	// read-back and read frame checks
	logic [6:0] read_toggle_stage;
	logic [6:0] next_read_toggle_stage;
	logic       check_pending;
	logic       next_check_pending;
	logic       frame_parity_error_flag;
	logic       next_frame_parity_error_flag;
	logic       check_char_error_flag;
	logic       next_check_char_error_flag;
	logic       vert_bad;

	assign vert_bad = pin_s.tape_frame[6]
		!= (sel_out.binary_mode ? ~^pin_s.tape_frame[5:0] : ^pin_s.tape_frame[5:0]);
	assign err_flags = {check_char_error_flag, frame_parity_error_flag, xmit_err};

	always_comb begin
		next_read_toggle_stage       = read_toggle_stage;
		next_check_pending           = check_pending | check_sent;
		next_frame_parity_error_flag = frame_parity_error_flag & ~err_clr[ERR_FRAME];
		next_check_char_error_flag   = check_char_error_flag & ~err_clr[ERR_CHECK];
		if (record_start) next_read_toggle_stage = '0; // see RQ27
		if (tape_tick) begin
			next_read_toggle_stage = read_toggle_stage ^ pin_s.tape_frame; // see RQ21
			if (vert_bad) next_frame_parity_error_flag = 1'b1; // see RQ20 see RQ22
			if (check_pending) begin
				next_check_pending = 1'b0;
				if ((read_toggle_stage ^ pin_s.tape_frame) != '0)
					next_check_char_error_flag = 1'b1; // see RQ21
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			read_toggle_stage       <= '0;
			check_pending           <= 1'b0;
			frame_parity_error_flag <= 1'b0;
			check_char_error_flag   <= 1'b0;
		end else begin
			read_toggle_stage       <= next_read_toggle_stage;
			check_pending           <= next_check_pending;
			frame_parity_error_flag <= next_frame_parity_error_flag;
			check_char_error_flag   <= next_check_char_error_flag;
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_REFUSE_BAD: assert property ( // see RQ2
		(f_state == F_IDLE && pin_s.func_strobe && !code_legal) |=> func_refuse && !func_accept)
		else $error("illegal function word not refused");
	AST_ACCEPT_LATE: assert property ( // see RQ3
		(f_state == F_IDLE && pin_s.func_strobe && code_legal) |=> !func_accept [*8] ##[1:600] func_accept)
		else $error("accept too early or missing");
	AST_MOTION_SEL: assert property ( // see RQ6
		$rose(func_accept) && fcode[5:3] == GRP_MOTION |-> sel_out.motion == (7'h01 << fcode[2:0]))
		else $error("motion selection not held");
	AST_XMIT_PAR: assert property ( // see RQ9
		word_take && !(^{pin_s.data_word, pin_s.data_parity}) |=> xmit_err)
		else $error("transmission parity error missed");
	AST_TAKE_READY: assert property ( // see RQ10
		$rose(word_accept) |-> $past(pin_s.handler_ready) && $past(w_state == W_IDLE))
		else $error("word taken while not ready");
	AST_UPPER_FIRST: assert property ( // see RQ26
		record_start && !ctrl.suppress_ad |=> disassembly_counter == 1'b0)
		else $error("record does not start on upper character");
	AST_CHECK_CLEAR: assert property ( // see RQ19
		check_sent |=> write_toggle_stage == '0 && !record_open)
		else $error("check character left write register set");
	AST_NO_ZERO: assert property ( // see RQ15
		(w_state == W_EMIT && frame_tick && coded_conv) |=> $past(frame[5:0]) != '0)
		else $error("zero character recorded in coded mode");
	AST_VERT_ERR: assert property ( // see RQ20
		tape_tick && vert_bad |=> frame_parity_error_flag)
		else $error("vertical parity error missed");

endmodule // tfw_top

`default_nettype wire

/* File: bench/tfw_handler_model.sv */
// tape handler model: rebuilds each written frame and plays it back as read-back
// assumes new write levels show two cycles after the frame strobe
`timescale 1ns/1ns
`default_nettype none

module tfw_handler_model (
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       frame_strobe,
	input  wire logic [6:0] write_level,
	input  wire logic       hold_off,
	input  wire logic       slow,
	input  wire logic       corrupt,
	output logic            handler_ready,
	output logic      [6:0] tape_frame,
	output logic            tape_strobe
);
	logic [6:0] last_level;
	logic [6:0] cnt;
	logic       seen;
	logic       seen2;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			last_level <= 7'h00;
			cnt <= 7'h00;
			seen <= 1'b0;
			seen2 <= 1'b0;
			handler_ready <= 1'b0;
			tape_frame <= 7'h00;
			tape_strobe <= 1'b0;
		end else begin
			handler_ready <= !hold_off;
			seen <= frame_strobe;
			seen2 <= seen;
			tape_strobe <= cnt > 7'h01 && cnt < 7'h06;
			if (seen2) begin
				// the level change is the frame; corrupt flips channel 0
				last_level <= write_level;
				tape_frame <= write_level ^ last_level ^ {6'h00, corrupt};
				cnt <= slow ? 7'h2C : 7'h08;
			end else if (cnt != 7'h00) begin
				cnt <= cnt - 7'h01;
				// released line shows the inverse, not a held value
				if (cnt == 7'h01)
					tape_frame <= ~tape_frame;
			end
		end
	end
endmodule // tfw_handler_model
`default_nettype wire

/* File: bench/tb_tape_function_select_and_write_path.sv */
// self-checking bench: function words, write records, registers over APB
// assumes the handler model on the tape side; channel pins driven here
`timescale 1ns/1ns
`default_nettype none

module tb_tape_function_select_and_write_path;
	import tfw_pkg::*;
	logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, e;
	logic        hold_off, slow, corrupt, hready, wstrobe, rstrobe, sup, sd, sd2;
	logic        faccept, frefuse, waccept;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [6:0]  tlevel, tframe;
	logic [6:0]  lv = 7'h00;
	logic [6:0]  fq[$], ex[$];
	int          tq[$];
	int          n_mismatch, comparisons, cyc;
	tfw_pins_t   drv, pins;
	tfw_sel_t    sel, es;
	logic [11:0] legal[23] = '{12'h001, 12'h003, 12'h004, 12'h006, 12'h021, 12'h020,
		12'h008, 12'h009, 12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h00E, 12'h010, 12'h012,
		12'h014, 12'h011, 12'h013, 12'h015, 12'h000, 12'h005, 12'h002, 12'h014};
	logic [11:0] illegal[6] = '{12'h007, 12'h00F, 12'h016, 12'h018, 12'h022, 12'h040};

	tfw_top uut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_in(pins), .sel_out(sel), .func_accept(faccept),
		.func_refuse(frefuse), .word_accept(waccept), .tape_write_level(tlevel),
		.tape_frame_strobe(wstrobe));
	tfw_handler_model hm (.clock(clock), .arst_n(arst_n), .frame_strobe(wstrobe),
		.write_level(tlevel), .hold_off(hold_off), .slow(slow), .corrupt(corrupt),
		.handler_ready(hready), .tape_frame(tframe), .tape_strobe(rstrobe));

	always_comb begin
		pins = drv;
		pins.handler_ready = hready;
		pins.tape_frame = tframe;
		pins.tape_strobe = rstrobe;
	end

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// frames written: the change of the levels after each strobe
	always @(posedge clock) begin
		if (sd2) begin
			fq.push_back(tlevel ^ lv);
			tq.push_back(cyc);
			lv = tlevel;
		end
		sd2 = sd;
		sd = wstrobe;
		cyc++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	function automatic tfw_sel_t upd(input tfw_sel_t s, input logic [11:0] c);
		case (c)
			12'h000: s.motion = 7'h00;
			12'h001: s.binary_mode = 1'b1;
			12'h002: s.binary_mode = 1'b0;
			12'h003: s.density = TFW_DEN_556;
			12'h004: s.density = TFW_DEN_200;
			12'h005: s = SEL_RESET;
			12'h006: s.density = TFW_DEN_800;
			12'h020: s.reverse_read = 1'b0;
			12'h021: s.reverse_read = 1'b1;
			default: if (c[5:3] == GRP_MOTION)
				s.motion = 7'h01 << c[2:0];
			else
				s.int_enable[c[2:1]] = !c[0];
		endcase
		return s;
	endfunction

	task automatic fn(input logic [11:0] c, input logic ok);
		int n;
		drv.func_word <= c;
		drv.func_strobe <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (faccept !== 1'b1 && frefuse !== 1'b1 && n < 900);
		chk(faccept, ok);
		chk(frefuse, !ok);
		chk(n > ACCEPT_CYC || !ok, 1);
		drv.func_strobe <= 1'b0;
		repeat (6) @(posedge clock);
		chk({faccept, frefuse}, 0);
		if (ok)
			es = upd(es, c);
		chk(sel, es);
	endtask

	function automatic logic [6:0] conv(input logic [5:0] c);
		if (!es.binary_mode && !drv.negate_conv) begin
			if (c == 6'h00)
				c = ZERO_CHAR_SUB;
			c[5] = c[5] ^ c[4];
		end
		return {es.binary_mode ? ~^c : ^c, c};
	endfunction

	task automatic word(input logic [11:0] w, input logic bad);
		int n;
		drv.data_word <= w;
		drv.data_parity <= ~^w ^ bad;
		drv.data_strobe <= 1'b1;
		if (!sup)
			ex.push_back(conv(w[11:6]));
		ex.push_back(conv(w[5:0]));
		if (hold_off) begin
			repeat (30) @(posedge clock);
			chk(waccept, 0);
			hold_off <= 1'b0;
		end
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waccept !== 1'b1 && n < 6000);
		chk(waccept, 1);
		drv.data_strobe <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waccept !== 1'b0 && n < 10);
		chk(waccept, 0);
	endtask

	// closes a record, compares its frames, check character and error flags
	task automatic rec(input logic [2:0] err);
		int n;
		logic [6:0] x;
		drv.write_req <= 1'b0;
		n = 0;
		x = 7'h00;
		do begin
			@(posedge clock);
			n++;
		end while (fq.size() <= ex.size() && n < 14000);
		foreach (ex[i]) begin
			chk(fq[i], ex[i]);
			x ^= ex[i];
		end
		chk(fq[ex.size()], x);
		chk(tq[ex.size()] - tq[ex.size() - 1], 4 * FRAME_CYC);
		chk(tlevel, 0);
		repeat (100) @(posedge clock);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q[2:0], err);
		apb(1'b1, REG_STATUS, 32'h7);
		fq.delete();
		tq.delete();
		ex.delete();
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		n_mismatch++;
		conclude;
	end

	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		drv = '0;
		{slow, corrupt, sup} = 3'h0;
		hold_off = 1'b1;
		es = SEL_RESET;
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		repeat (6) @(posedge clock);
		chk(sel, SEL_RESET);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, 0);
		apb(1'b1, REG_CTRL, 32'hFFFFFFFF);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(q, 1);
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk({e, q[30:0]}, 32'h80000000);
		foreach (legal[i]) fn(legal[i], 1'b1);
		foreach (illegal[i]) fn(illegal[i], 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q[17:0], {1'b0, es, 3'h0});
		drv.write_req <= 1'b1;
		word(12'h419, 1'b0);
		word(12'h00F, 1'b0);
		word(12'hAAA, 1'b1);
		rec(3'h1);
		fn(12'h001, 1'b1);
		slow <= 1'b1;
		drv.write_req <= 1'b1;
		word(12'h400, 1'b0);
		// binary check char of an even frame count fails vertical parity
		rec(3'h2);
		fn(12'h002, 1'b1);
		apb(1'b1, REG_CTRL, 32'h1);
		sup = 1'b1;
		drv.negate_conv <= 1'b1;
		corrupt <= 1'b1;
		drv.write_req <= 1'b1;
		@(posedge clock);
		word(12'hFC0, 1'b0);
		while (fq.size() == 0)
			@(posedge clock);
		repeat (60) @(posedge clock);
		corrupt <= 1'b0;
		rec(3'h6);
		conclude;
	end
endmodule // tb_tape_function_select_and_write_path
`default_nettype wire
